// ---- hw/lcc_pkg.sv ----
/*
 * lcc_pkg: register map, field layouts, reset values and timing counts
 * shared by the logic cell group and its cells.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per
 * register.
 */
package lcc_pkg;

	// ==========================================================
	// geometry and timing
	localparam int LCC_CELLS = 8; // cells in one group
	localparam int LCC_ROW_GROUPS = 36; // groups in one row
	localparam int LCC_LAST_BEFORE_MEM = 18; // last group left of memory
	localparam int LCC_GROUP_INDEX = 1; // this group, counted from 1
	localparam int LCC_TICK_DIV = 4; // core cycles per free-running tick
	localparam int LCC_ADDR_W = 8;

	// ==========================================================
	// register map, byte offsets
	localparam logic [7:0] LCC_OFF_CTRL = 8'h00;
	localparam logic [7:0] LCC_OFF_DATA = 8'h04;
	localparam logic [7:0] LCC_OFF_OE = 8'h08;
	localparam logic [7:0] LCC_OFF_STATUS = 8'h0c;
	localparam logic [7:0] LCC_OFF_CFG0 = 8'h40; // one word per cell

	// ==========================================================
	// cell operating modes and clear/preset modes
	typedef enum logic [1:0] {
		LCC_NORMAL,
		LCC_ARITH,
		LCC_UPDOWN,
		LCC_CLRCNT
	} lcc_mode_t;

	typedef enum logic [2:0] {
		LCC_CP_CLR,
		LCC_CP_PRE,
		LCC_CP_CLR_PRE,
		LCC_CP_LOAD_CLR,
		LCC_CP_LOAD_PRE,
		LCC_CP_LOAD
	} lcc_cpmode_t;

	// per-cell configuration word, bit 0 upward from the right
	typedef struct packed {
		logic swap_out; // packed: register drives local output
		logic out_reg; // unpacked: register drives both outputs
		logic ce_from_d1; // clock enable taken from enable_data_input
		logic cascade_or; // cascade joins by or instead of and
		logic carry_to_lut; // carry-in replaces load_data_input at lut
		logic packed_reg; // register fed by direct_register_input
		lcc_cpmode_t cp_mode;
		lcc_mode_t mode;
		logic [15:0] lut_mask;
	} lcc_cfg_t;

	// control word; step is a write-only strobe
	typedef struct packed {
		logic preset_on_reset; // chip reset presets preset-capable cells
		logic reset_en; // chip-wide reset pin in use
		logic run; // free-running tick from the divider
		logic step; // one tick per write of one
	} lcc_ctrl_t;

	// status word, read only
	typedef struct packed {
		logic link_ok; // chains continue into next_group
		logic [7:0] next_group;
		logic tri_bus;
		logic cascade_last;
		logic carry_last; // final carry-out, general-purpose
		logic [7:0] comb;
		logic [7:0] q;
	} lcc_status_t;

	localparam lcc_cfg_t LCC_CFG_RESET = '0;
	localparam lcc_ctrl_t LCC_CTRL_RESET = '0;
	localparam logic [31:0] LCC_DATA_RESET = 32'h0000_0000;
	localparam logic [7:0] LCC_OE_RESET = 8'h00;

	// byte-lane merge for register writes
	function automatic logic [31:0] lcc_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction : lcc_merge

endpackage : lcc_pkg

// ---- hw/lcc_cell.sv ----
/*
 * lcc_cell: one logic cell with lut, register, carry and cascade links.
 * Assumes a single core clock; the cell register takes reg_d only on tick, overrides act in any cycle,
 * and the group controls come from logic on the same clock.
 */
`timescale 1ns/10ps
module lcc_cell (
	// clock, reset and register tick
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	// configuration
	input wire lcc_pkg::lcc_cfg_t cfg,
	// data and chain inputs
	input wire logic [3:0] data,
	input wire logic carry_in,
	input wire logic cascade_in,
	// group controls and chip-wide reset, asserted high
	input wire logic ctl_a,
	input wire logic ctl_b,
	input wire logic chip_rst,
	input wire logic preset_on_reset,
	// chain and cell outputs
	output logic carry_out,
	output logic cascade_out,
	output logic comb_out,
	output logic q,
	output logic local_out,
	output logic row_out
);
	import lcc_pkg::*;

	// ==========================================================
	// lut datapath
	logic q_ff;
	logic nxt_q;
	wire is_norm = (cfg.mode == LCC_NORMAL);
	wire is_cnt = (cfg.mode == LCC_UPDOWN) || (cfg.mode == LCC_CLRCNT);
	// third lut input: carry-in or load_data_input
	wire lut_c = cfg.carry_to_lut ? carry_in : data[2];
	wire [3:0] idx4 = {data[3], lut_c, data[1], data[0]};
	// counters feed back the register; up/down adds direction
	wire dir = (cfg.mode == LCC_UPDOWN) ? data[1] : 1'b0;
	wire [2:0] idx3 = is_cnt ? {carry_in, q_ff, dir}
		: {carry_in, data[1], data[0]};
	wire lut3_lo = cfg.lut_mask[idx3];
	wire lut3_hi = cfg.lut_mask[4'(8 + idx3)];
	wire lut4 = cfg.lut_mask[idx4];
	// synchronous load mux; clearable counter ands in cascade clear
	wire load_mux = data[3] ? data[2] : lut3_lo;
	wire cnt_d = (cfg.mode == LCC_CLRCNT) ? (load_mux & cascade_in)
		: load_mux;
	assign comb_out = is_norm ? lut4 : lut3_lo;
	// in normal mode carry passes on to the next cell as well as into the lut
	assign carry_out = is_norm ? carry_in : lut3_hi;
	// packed registers and counters stay off the cascade chain
	wire cas_join = cfg.cascade_or ? (comb_out | cascade_in)
		: (comb_out & cascade_in);
	assign cascade_out = (cfg.packed_reg || is_cnt) ? cascade_in
		: cas_join;

	// ==========================================================
	// clear, preset and load controls, clear and preset active low inside
	logic clear_low;
	logic preset_low;
	logic load_on;
	always_comb begin
		clear_low = 1'b1; // unused clear and preset held high, load held low
		preset_low = 1'b1;
		load_on = 1'b0;
		case (cfg.cp_mode)
			LCC_CP_CLR: clear_low = ~(ctl_a | ctl_b);
			LCC_CP_PRE: preset_low = ~ctl_a;
			LCC_CP_CLR_PRE: begin
				preset_low = ~ctl_a;
				clear_low = ~ctl_b;
			end
			LCC_CP_LOAD_CLR: begin
				load_on = ctl_a;
				clear_low = ~ctl_b;
			end
			LCC_CP_LOAD_PRE: begin
				load_on = ctl_a;
				preset_low = ~ctl_b;
			end
			LCC_CP_LOAD: load_on = ctl_a;
			default: clear_low = 1'b1;
		endcase
	end

	// ==========================================================
	// register next value: reset, then overrides, then enabled tick
	wire pre_cap = (cfg.cp_mode == LCC_CP_PRE)
		|| (cfg.cp_mode == LCC_CP_CLR_PRE)
		|| (cfg.cp_mode == LCC_CP_LOAD_PRE);
	wire ce = cfg.ce_from_d1 ? data[0] : 1'b1;
	wire reg_d = cfg.packed_reg ? data[3]
		: (is_cnt ? cnt_d : comb_out);
	always_comb begin
		if (chip_rst) begin
			nxt_q = preset_on_reset & pre_cap;
		end else if (!clear_low) begin
			nxt_q = 1'b0;
		end else if (!preset_low) begin
			nxt_q = 1'b1;
		end else if (load_on) begin
			nxt_q = data[2];
		end else if (tick && ce) begin
			nxt_q = reg_d;
		end else begin
			nxt_q = q_ff;
		end
	end

	// overrides act every cycle, not only on tick, so they need no lut
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_ff <= 1'b0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ==========================================================
	// output steering
	assign q = q_ff;
	assign local_out = cfg.packed_reg ? (cfg.swap_out ? q_ff : comb_out)
		: (cfg.out_reg ? q_ff : comb_out);
	assign row_out = cfg.packed_reg ? (cfg.swap_out ? comb_out : q_ff)
		: (cfg.out_reg ? q_ff : comb_out);

endmodule : lcc_cell

// ---- hw/lcc_group.sv ----
/*
 * lcc_group: a group of logic cells joined by carry and cascade chains,
 * with an Avalon-MM register slave, a chip-reset synchroniser, a tick
 * divider and an emulated internal tri-state bus.
 * Assumes neighbouring groups and group controls run on CORE_CLK; only
 * the chip-wide reset pin arrives from outside that domain.
 */
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/10ps

// Summary of operation
// - carry-in feeds the cell lut and the next carry stage.
// - carry chains beyond eight cells skip to group index plus two.
// - chains stop at the memory block mid-row, restart beyond it.
// - n-bit adder uses n cells; last carry is a plain signal.
// - cascade joins lut outputs by and, or by or via inversion.
// - each cascaded cell adds four inputs to the function.
// - cascade beyond eight cells skips alternate groups, not mid-row.
// - four cell modes: normal, arithmetic, up/down, clearable counter.
// - seven logic inputs plus clock, clear and preset per cell.
// - register clock enable in every mode, may come from data one.
// - normal mode lut takes carry-in or load data input.
// - normal lut joins cascade; register or lut drives both outputs.
// - packed register takes direct input, own outputs, no cascade.
// - arithmetic: two three-input luts, sum and carry, cascade usable.
// - up/down counter: direction, enable, load mux, two luts.
// - up/down counter may load through clear and preset controls.
// - clearable counter ands the load mux with a cascade-path clear.
// - tri-state emulation: contention reads low, no driver reads high.
// - either group control clears, or control a loads data three.
// - clear and preset are active low, unused ones held high.
// - six clear/preset modes selectable per cell.
// - chip-wide reset overrides all; may preset preset-capable cells.
// - clear-and-preset: control a presets, control b clears.
// - preset-only: control a loads a one.
module lcc_group #(
	parameter int CELLS = lcc_pkg::LCC_CELLS,
	parameter int GROUP_INDEX = lcc_pkg::LCC_GROUP_INDEX,
	parameter int ROW_GROUPS = lcc_pkg::LCC_ROW_GROUPS,
	parameter int LAST_BEFORE_MEM = lcc_pkg::LCC_LAST_BEFORE_MEM,
	parameter int TICK_DIV = lcc_pkg::LCC_TICK_DIV
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// avalon-mm register slave
	input wire logic [lcc_pkg::LCC_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// chains from the lower-order group
	input wire logic CARRY_IN,
	input wire logic CASCADE_IN,
	// group control lines, asserted high
	input wire logic GROUP_CONTROL_A,
	input wire logic GROUP_CONTROL_B,
	// chip-wide reset pin
	input wire logic CHIP_RESET_N,
	// chains to the higher-order group
	output logic CARRY_OUT,
	output logic CASCADE_OUT,
	// cell outputs and emulated bus
	output logic [CELLS-1:0] LOCAL_OUT,
	output logic [CELLS-1:0] ROW_OUT,
	output logic TRI_BUS
);
	import lcc_pkg::*;

	// ==========================================================
	// elaboration checks
	generate
		if (CELLS < 1 || CELLS > 8) begin : g_bad_cells
			$error("cells per group must be 1 to 8");
		end
		if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
			$error("tick divider out of range");
		end
		if (GROUP_INDEX < 1 || GROUP_INDEX > ROW_GROUPS) begin : g_bad_idx
			$error("group index outside the row");
		end
		if (LAST_BEFORE_MEM >= ROW_GROUPS) begin : g_bad_mem
			$error("memory block must sit inside the row");
		end
	endgenerate

	// ==========================================================
	// declarations
	lcc_ctrl_t ctrl_ff;
	lcc_cfg_t cfg_ff [CELLS];
	logic [4*CELLS-1:0] data_ff;
	logic [CELLS-1:0] oe_ff;
	logic ack_ff;
	logic [31:0] rd_word;
	logic [31:0] AVS_READDATA_ff;
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic pin_s3_ff;
	logic chip_rst_ff;
	logic [15:0] div_ff;
	logic [15:0] nxt_div;
	logic [CELLS:0] carry_c;
	logic [CELLS:0] cas_c;
	logic [CELLS-1:0] q_vec;
	logic [CELLS-1:0] comb_vec;
	lcc_status_t status;

	// ==========================================================
	// chip-wide reset pin: three flops, accepted when two agree
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
			pin_s3_ff <= 1'b1;
			chip_rst_ff <= 1'b0;
		end else begin
			pin_s1_ff <= CHIP_RESET_N;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			if (pin_s2_ff == pin_s3_ff) begin
				chip_rst_ff <= ~pin_s3_ff;
			end
		end
	end

	// reset is optional, switched in from the control word
	wire chip_rst = chip_rst_ff & ctrl_ff.reset_en;

	// ==========================================================
	// avalon slave handshake: one wait cycle for every access
	wire bus_req = AVS_READ | AVS_WRITE;
	wire wr_en = AVS_WRITE & ack_ff;
	wire rd_take = AVS_READ & ~ack_ff;
	assign AVS_WAITREQUEST = bus_req & ~ack_ff;
	assign AVS_READDATA = AVS_READDATA_ff;

	// ack pulses once per request, so back-to-back requests each wait
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
		end
	end

	// read data captured early so it stands for the whole answer cycle
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			AVS_READDATA_ff <= 32'h0000_0000;
		end else if (rd_take) begin
			AVS_READDATA_ff <= rd_word;
		end
	end

	// ==========================================================
	// address decode
	wire hit_ctrl = (AVS_ADDRESS == LCC_OFF_CTRL);
	wire hit_data = (AVS_ADDRESS == LCC_OFF_DATA);
	wire hit_oe = (AVS_ADDRESS == LCC_OFF_OE);
	wire hit_stat = (AVS_ADDRESS == LCC_OFF_STATUS);
	wire [2:0] cfg_idx = AVS_ADDRESS[4:2];
	wire hit_cfg = (AVS_ADDRESS[7:5] == LCC_OFF_CFG0[7:5])
		&& (AVS_ADDRESS[1:0] == 2'h0)
		&& (int'(cfg_idx) < CELLS);

	// merged write words, byte lanes applied
	wire [31:0] ctrl_new = lcc_merge(32'(ctrl_ff), AVS_WRITEDATA,
		AVS_BYTEENABLE);
	wire [31:0] data_new = lcc_merge(32'(data_ff), AVS_WRITEDATA,
		AVS_BYTEENABLE);
	wire [31:0] oe_new = lcc_merge(32'(oe_ff), AVS_WRITEDATA,
		AVS_BYTEENABLE);
	wire [31:0] cfg_new = lcc_merge(32'(cfg_ff[cfg_idx]), AVS_WRITEDATA,
		AVS_BYTEENABLE);
	wire step_pulse = wr_en & hit_ctrl & ctrl_new[0];

	// ==========================================================
	// software registers; unmapped writes fall through unused
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_ff <= LCC_CTRL_RESET;
			data_ff <= LCC_DATA_RESET[4*CELLS-1:0];
			oe_ff <= LCC_OE_RESET[CELLS-1:0];
		end else if (wr_en) begin
			if (hit_ctrl) begin
				// step is a strobe and is never stored
				ctrl_ff <= lcc_ctrl_t'({ctrl_new[3:1], 1'b0});
			end else if (hit_data) begin
				data_ff <= data_new[4*CELLS-1:0];
			end else if (hit_oe) begin
				oe_ff <= oe_new[CELLS-1:0];
			end
		end
	end

	// per-cell configuration words, one flop bank indexed by cell
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			for (int i = 0; i < CELLS; i++) begin
				cfg_ff[i] <= LCC_CFG_RESET;
			end
		end else if (wr_en && hit_cfg) begin
			cfg_ff[cfg_idx] <= lcc_cfg_t'(cfg_new[26:0]);
		end
	end

	// ==========================================================
	// read mux; unmapped addresses read zero
	always_comb begin
		if (hit_ctrl) begin
			rd_word = 32'(ctrl_ff);
		end else if (hit_data) begin
			rd_word = 32'(data_ff);
		end else if (hit_oe) begin
			rd_word = 32'(oe_ff);
		end else if (hit_stat) begin
			rd_word = 32'(status);
		end else if (hit_cfg) begin
			rd_word = 32'(cfg_ff[cfg_idx]);
		end else begin
			rd_word = 32'h0000_0000;
		end
	end

	// ==========================================================
	// register tick: software step or divided free-running enable
	wire div_wrap = (div_ff == 16'(TICK_DIV - 1));
	assign nxt_div = (!ctrl_ff.run || div_wrap) ? 16'h0000
		: 16'(div_ff + 16'h0001);

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// the divider keeps the cell clock one enable, never a second clock
	wire tick = step_pulse | (ctrl_ff.run & div_wrap);

	// ==========================================================
	// chain link to the next group of the same parity, never past
	// the memory block in the middle of the row
	localparam int NEXT_GROUP = GROUP_INDEX + 2;
	localparam bit LINK_OK = (NEXT_GROUP <= ROW_GROUPS)
		&& ((GROUP_INDEX <= LAST_BEFORE_MEM)
		== (NEXT_GROUP <= LAST_BEFORE_MEM));

	assign carry_c[0] = CARRY_IN;
	assign cas_c[0] = CASCADE_IN;
	// a stopped chain hands on neutral values: no carry, and-identity
	assign CARRY_OUT = LINK_OK ? carry_c[CELLS] : 1'b0;
	assign CASCADE_OUT = LINK_OK ? cas_c[CELLS] : 1'b1;

	// ==========================================================
	// the cells, each taking four data bits and the chains
	generate
		for (genvar i = 0; i < CELLS; i++) begin : g_cell
			lcc_cell u_cell (
				.clk(CORE_CLK),
				.rst(RESET),
				.tick(tick),
				.cfg(cfg_ff[i]),
				.data(data_ff[4*i +: 4]),
				.carry_in(carry_c[i]),
				.cascade_in(cas_c[i]),
				.ctl_a(GROUP_CONTROL_A),
				.ctl_b(GROUP_CONTROL_B),
				.chip_rst(chip_rst),
				.preset_on_reset(ctrl_ff.preset_on_reset),
				.carry_out(carry_c[i+1]),
				.cascade_out(cas_c[i+1]),
				.comb_out(comb_vec[i]),
				.q(q_vec[i]),
				.local_out(LOCAL_OUT[i]),
				.row_out(ROW_OUT[i])
			);
		end
	endgenerate

	// ==========================================================
	// emulated tri-state bus over the local outputs
	wire tri_none = ~|oe_ff;
	wire tri_multi = |(oe_ff & (oe_ff - CELLS'(1)));
	wire tri_val = |(oe_ff & LOCAL_OUT);
	// a mux cannot float or fight, so those cases get fixed levels
	assign TRI_BUS = tri_none ? 1'b1
		: (tri_multi ? 1'b0 : tri_val);

	// ==========================================================
	// status word
	assign status.link_ok = LINK_OK;
	assign status.next_group = LINK_OK ? 8'(NEXT_GROUP) : 8'h00;
	assign status.tri_bus = TRI_BUS;
	assign status.cascade_last = cas_c[CELLS];
	assign status.carry_last = carry_c[CELLS];
	assign status.comb = 8'(comb_vec);
	assign status.q = 8'(q_vec);

endmodule : lcc_group

// ---- bench/lcc_group_checker.sv ----
/*
 * lcc_group_checker: port-level assertions for the logic cell group.
 * Assumes it is bound into lcc_group and sees only that module's ports.
 */
`timescale 1ns/10ps
module lcc_group_checker import lcc_pkg::*; #(
	parameter int CELLS = 8
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// register slave
	input wire logic [lcc_pkg::LCC_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// chains and controls
	input wire logic CARRY_IN,
	input wire logic CASCADE_IN,
	input wire logic GROUP_CONTROL_A,
	input wire logic GROUP_CONTROL_B,
	input wire logic CHIP_RESET_N,
	input wire logic CARRY_OUT,
	input wire logic CASCADE_OUT,
	// cell outputs
	input wire logic [CELLS-1:0] LOCAL_OUT,
	input wire logic [CELLS-1:0] ROW_OUT,
	input wire logic TRI_BUS
);
	// ==========================================================
	// bus handshake
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	// a request is taken while waitrequest is high
	sequence s_taken;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	sequence s_answer;
		!AVS_WAITREQUEST;
	endsequence
	// first edge after reset release, nothing configured yet
	sequence s_fresh;
		$fell(RESET);
	endsequence

	a_wait_one_cycle: assert property (s_taken |=> s_answer)
		else $error("waitrequest not low one cycle after take");
	a_request_stalls: assert property ($rose(AVS_READ || AVS_WRITE)
		|-> AVS_WAITREQUEST)
		else $error("new request not stalled");
	// read data must not move unless a read is being taken
	a_rdata_holds: assert property (!(AVS_READ && AVS_WAITREQUEST)
		|=> $stable(AVS_READDATA))
		else $error("read data changed without a read");

	// ==========================================================
	// cleared configuration seen right after reset
	a_fresh_rdata: assert property (s_fresh |-> AVS_READDATA == 32'h0)
		else $error("read data not zero after reset");
	a_fresh_tri_high: assert property (s_fresh |-> TRI_BUS)
		else $error("undriven bus not high");
	a_fresh_carry_pass: assert property (s_fresh
		|-> CARRY_OUT == CARRY_IN)
		else $error("carry not passed along chain");
	a_fresh_cascade: assert property (s_fresh |-> !CASCADE_OUT)
		else $error("cascade not and of zero luts");
	a_fresh_outs: assert property (s_fresh
		|-> LOCAL_OUT == '0 && ROW_OUT == '0)
		else $error("cell outputs not cleared lut value");
endmodule : lcc_group_checker

// every checker port matches a group port of the same name
bind lcc_group lcc_group_checker #(.CELLS(CELLS)) lcc_group_checker_inst (.*);

// ---- bench/lcc_partner.sv ----
/*
 * lcc_partner: the lower-order neighbour group and group control source.
 * Assumes the bench calls drive() right after a rising clock edge.
 */
`timescale 1ns/10ps
module lcc_partner (
	// clock
	input wire logic clk,
	// chain and control lines toward the group
	output logic carry,
	output logic cascade,
	output logic ctl_a,
	output logic ctl_b,
	output logic chip_rst_n
);
	// quiet neighbour: no carry, no cascade, controls idle
	initial begin
		carry = 1'b0;
		cascade = 1'b0;
		ctl_a = 1'b0;
		ctl_b = 1'b0;
		chip_rst_n = 1'b1;
	end

	// levels change only just after an edge, same clock as the group
	task automatic drive(input logic c, s, a, b, n);
		@(posedge clk);
		carry <= c;
		cascade <= s;
		ctl_a <= a;
		ctl_b <= b;
		chip_rst_n <= n;
	endtask : drive
endmodule : lcc_partner

// ---- bench/lcc_group_tb_top.sv ----
/*
 * lcc_group_tb_top: self-checking bench for the logic cell group.
 * Assumes default group parameters (8 cells, group 1 of 36).
 */
`timescale 1ns/10ps
module lcc_group_tb_top;
	import lcc_pkg::*;
	logic clk, rst, rd, wr, wait_q, cin, casc, ca, cb, crn, cout, cdout, tri_q;
	logic [7:0] adr, lo, ro, c2l, ex, oe;
	logic [31:0] wdat, rdat, q, dv, cv;
	logic [3:0] be, a, b, idx;
	logic [4:0] sum;
	logic [15:0] mk [8];
	logic [31:0] mdl [int];
	int fail_count, n_compared;

	lcc_group lcc_group_inst (.CORE_CLK(clk), .RESET(rst),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wait_q), .CARRY_IN(cin), .CASCADE_IN(casc),
		.GROUP_CONTROL_A(ca), .GROUP_CONTROL_B(cb), .CHIP_RESET_N(crn),
		.CARRY_OUT(cout), .CASCADE_OUT(cdout), .LOCAL_OUT(lo),
		.ROW_OUT(ro), .TRI_BUS(tri_q));
	lcc_partner lcc_partner_inst (.clk(clk), .carry(cin), .cascade(casc),
		.ctl_a(ca), .ctl_b(cb), .chip_rst_n(crn));

	// ==========================================================
	// reporting
	task automatic chk(input string what, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic print_verdict;
		if (fail_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	// ==========================================================
	// avalon master: hold until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		logic done;
		n = 0;
		@(posedge clk);
		adr <= ad;
		wdat <= d;
		rd <= !w;
		wr <= w;
		// mid-cycle look shows what the next rising edge will sample
		do begin
			@(negedge clk);
			done = (wait_q === 1'b0);
			r = rdat;
			n++;
			@(posedge clk);
		end while (!done && n < 100);
		rd <= 1'b0;
		wr <= 1'b0;
		if (!done) fail_count++;
	endtask : bus

	// writable bits per register; step strobe reads back zero
	function automatic logic [31:0] msk(input logic [7:0] ad);
		case (ad)
			LCC_OFF_CTRL: return 32'h0000_000e;
			LCC_OFF_DATA: return 32'hffff_ffff;
			LCC_OFF_OE: return 32'h0000_00ff;
			default: return 32'h07ff_ffff;
		endcase
	endfunction : msk

	task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, q);
		if (mdl.exists(int'(ad))) mdl[int'(ad)] = d & msk(ad);
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] ad);
		bus(1'b0, ad, 32'h0, q);
		chk("register", mdl.exists(int'(ad)) ? mdl[int'(ad)] : 32'h0, q);
	endtask : rd_chk

	// fl = {swap, out_reg, ce_from_d1, cascade_or, carry_to_lut, packed}
	function automatic logic [31:0] cfgw(input logic [15:0] m,
		input logic [1:0] md, input logic [2:0] cp, input logic [5:0] fl);
		return {5'h0, fl, cp, md, m};
	endfunction : cfgw

	// one register step of cell 0, watched on its row output
	task automatic reg_case(input logic [31:0] cw, input logic [3:0] d,
		input logic s, ia, ib, st, e);
		wr_reg(LCC_OFF_CFG0, cw);
		wr_reg(LCC_OFF_DATA, {28'h0, d});
		lcc_partner_inst.drive(1'b0, s, ia, ib, 1'b1);
		if (st) wr_reg(LCC_OFF_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk("cell0 register", {31'h0, e}, {31'h0, ro[0]});
		lcc_partner_inst.drive(1'b0, s, 1'b0, 1'b0, 1'b1);
	endtask : reg_case

	// ==========================================================
	// clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// a hang of about thirty times the expected run length ends the test
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = '0; wdat = '0; be = 4'hf;
		fail_count = 0;
		n_compared = 0;
		mdl[LCC_OFF_CTRL] = 0; mdl[LCC_OFF_DATA] = 0; mdl[LCC_OFF_OE] = 0;
		for (int i = 0; i < 8; i++) mdl[LCC_OFF_CFG0 + 4 * i] = 0;
		void'($urandom(8));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// status after reset, then a write that must be ignored
		for (int k = 0; k < 2; k++) begin
			bus(1'b0, LCC_OFF_STATUS, 32'h0, q);
			chk("status", {4'h0, 1'b1, 8'(LCC_GROUP_INDEX + 2), 1'b1, 18'h0}, q);
			wr_reg(LCC_OFF_STATUS, 32'hffff_ffff);
		end
		// reset values, random write, read back, unmapped place too
		for (int k = 0; k < 2; k++) begin
			foreach (mdl[i]) rd_chk(8'(i));
			rd_chk(8'h30);
			foreach (mdl[i]) wr_reg(8'(i), $urandom & 32'hffef_fffd);
			wr_reg(8'h30, $urandom);
		end
		// normal mode luts, cascade join and emulated bus
		for (int it = 0; it < 6; it++) begin
			c2l = 8'($urandom);
			cv = $urandom;
			dv = $urandom;
			for (int i = 0; i < 8; i++) begin
				mk[i] = 16'($urandom);
				wr_reg(LCC_OFF_CFG0 + 8'(4 * i), cfgw(mk[i], 2'd0, 3'd0, {4'h0, c2l[i], 1'b0}));
				idx = {dv[4*i+3], c2l[i] ? cv[0] : dv[4*i+2], dv[4*i+1], dv[4*i]};
				ex[i] = mk[i][idx];
			end
			oe = (it == 0) ? 8'h00 : (it == 1) ? 8'h81 : 8'h1 << ($urandom % 8);
			wr_reg(LCC_OFF_DATA, dv);
			wr_reg(LCC_OFF_OE, {24'h0, oe});
			lcc_partner_inst.drive(cv[0], cv[1], 1'b0, 1'b0, 1'b1);
			repeat (2) @(posedge clk);
			chk("local_out", {24'h0, ex}, {24'h0, lo});
			chk("row_out", {24'h0, ex}, {24'h0, ro});
			chk("cascade_out", {31'h0, cv[1] & (&ex)}, {31'h0, cdout});
			chk("carry_out", {31'h0, cv[0]}, {31'h0, cout});
			chk("tri_bus", {31'h0, (oe == 0) ? 1'b1 : ($countones(oe) > 1) ? 1'b0 : |(ex & oe)}, {31'h0, tri_q});
		end
		// four-bit adder in arithmetic cells, carry leaves the group
		for (int i = 0; i < 8; i++) wr_reg(LCC_OFF_CFG0 + 8'(4 * i), (i < 4) ? cfgw(16'he896, 2'd1, 3'd0, 6'h0) : 32'h0);
		for (int it = 0; it < 6; it++) begin
			a = 4'($urandom);
			b = 4'($urandom);
			cv = $urandom;
			sum = a + b + cv[0];
			dv = '0;
			for (int i = 0; i < 4; i++) dv[4*i +: 2] = {b[i], a[i]};
			wr_reg(LCC_OFF_DATA, dv);
			lcc_partner_inst.drive(cv[0], 1'b0, 1'b0, 1'b0, 1'b1);
			repeat (2) @(posedge clk);
			chk("sum", {28'h0, sum[3:0]}, {28'h0, lo[3:0]});
			chk("final carry", {31'h0, sum[4]}, {31'h0, cout});
		end
		// register enable, clear, preset, load and counter paths
		wr_reg(LCC_OFF_CTRL, 32'h0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd0, 6'h10), 4'h0, 0, 0, 1, 0, 0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd0, 6'h18), 4'h0, 0, 0, 0, 1, 0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd0, 6'h18), 4'h1, 0, 0, 0, 1, 1);
		reg_case(cfgw(16'hffff, 2'd0, 3'd0, 6'h10), 4'h0, 0, 1, 0, 0, 0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd0, 6'h10), 4'h0, 0, 0, 0, 1, 1);
		reg_case(cfgw(16'hffff, 2'd0, 3'd2, 6'h10), 4'h0, 0, 0, 1, 0, 0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd2, 6'h10), 4'h0, 0, 1, 0, 0, 1);
		reg_case(cfgw(16'hffff, 2'd0, 3'd2, 6'h10), 4'h0, 0, 1, 1, 0, 0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd5, 6'h10), 4'h4, 0, 1, 0, 0, 1);
		reg_case(cfgw(16'hffff, 2'd0, 3'd5, 6'h10), 4'h0, 0, 1, 0, 0, 0);
		reg_case(cfgw(16'hffff, 2'd0, 3'd1, 6'h10), 4'h4, 0, 1, 0, 0, 1);
		reg_case(cfgw(16'h00ff, 2'd3, 3'd0, 6'h10), 4'h0, 0, 0, 0, 1, 0);
		reg_case(cfgw(16'h00ff, 2'd3, 3'd0, 6'h10), 4'h0, 1, 0, 0, 1, 1);
		reg_case(cfgw(16'h00ff, 2'd2, 3'd0, 6'h10), 4'h8, 0, 0, 0, 1, 0);
		reg_case(cfgw(16'h00ff, 2'd2, 3'd0, 6'h10), 4'h0, 0, 0, 0, 1, 1);
		// chip-wide reset through its synchroniser
		wr_reg(LCC_OFF_CTRL, 32'h4);
		lcc_partner_inst.drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk("chip reset", 32'h0, {31'h0, ro[0]});
		lcc_partner_inst.drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		print_verdict();
	end
endmodule : lcc_group_tb_top
